// File: logic/ms_pkg.sv
// Purpose: Shared constants and types for the measurement sequencer.
// Assumes: One module clock; register port with one-cycle read latency.
// Notes: Offsets are byte addresses of 32-bit words.
package ms_pkg;

    localparam int ADDR_W = 8;
    localparam int REG_W = 32;
    localparam int SMP_W = 24;
    localparam int CNT_W = 24;

    // Register offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_SETTLE = 8'h08;
    localparam logic [7:0] OFS_PRETRIG = 8'h0C;
    localparam logic [7:0] OFS_BLOCK = 8'h10;
    localparam logic [7:0] OFS_DECIM = 8'h14;
    localparam logic [7:0] OFS_RATE = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;

    // Command bits in the control register (write only, self clearing).
    localparam int CMD_INIT = 0;
    localparam int CMD_ARM = 1;
    localparam int CMD_TRIG = 2;
    localparam int CMD_RESET = 3;

    // Configuration field positions.
    localparam int CFG_MULTI = 0;
    localparam int CFG_AUTO_ARM = 1;
    localparam int CFG_AUTO_TRIG = 2;
    localparam int CFG_TRIG_DRIVE = 3;
    localparam int CFG_CONT = 4;
    localparam int CFG_PREARM_AUTO = 5;
    localparam logic [5:0] CFG_RESET = 6'h20;

    // Decimation field layout: divide-by-two count and divide-by-five flag.
    localparam int DEC_DIV5 = 5;
    localparam logic [4:0] DEC_MAX_DIV2 = 5'h10;

    // Sample rates 48000.0 to 196608.0 Hz form a list of this many entries.
    localparam logic [4:0] RATE_COUNT = 5'h1B;
    localparam logic [4:0] RATE_RESET = 5'h00;

    localparam logic [CNT_W-1:0] SETTLE_RESET = 24'h000040;
    localparam logic [CNT_W-1:0] BLOCK_RESET = 24'h000400;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0] wdata;
        logic wr;
        logic rd;
    } ms_bus_t;

    typedef struct packed {
        logic valid;
        logic [SMP_W-1:0] data;
    } ms_sample_t;

    typedef struct packed {
        logic wr;
        logic drop;
        logic [SMP_W-1:0] data;
    } ms_fifo_t;

    typedef struct packed {
        logic div5;
        logic [4:0] div2;
    } ms_decim_t;

    typedef enum logic [3:0] {
        ST_PARAM_SETUP,
        ST_BOOT_LOADING,
        ST_BOOTED,
        ST_FILTER_SETTLE,
        ST_PREARM,
        ST_IDLE,
        ST_ARM,
        ST_TRIGGER,
        ST_ACQUIRE
    } ms_state_t;

endpackage : ms_pkg

// File: logic/ms_seq.sv
// Purpose: Measurement sequencer driving the shared wire-OR sync line.
// Assumes: Sample stream, trigger and boot inputs come from core_clk logic;
//          only the backplane sync pin is asynchronous.
// Notes: Parameters written to the shadow registers take effect at init.
//
// Contract
// [RULE1] States begin on line fall, end on rise.
// [RULE2] Line is wire-OR; any module holds low.
// [RULE3] Single module keeps the line internal.
// [RULE4] Sample clock toggles steadily through all states.
// [RULE5] Reset enters parameter setup until line falls.
// [RULE6] Boot loads, then releases line, enters booted.
// [RULE7] Booted waits for line fall, then settles.
// [RULE8] Settle discards configured samples, then pre-arm.
// [RULE9] Pre-arm waits condition, releases, then idle.
// [RULE10] Idle writes nothing; arm on fall/rpm/software.
// [RULE11] Auto arm pulls line low in idle.
// [RULE12] Arm stores samples until line goes high.
// [RULE13] Arm releases after pre-trigger samples collected.
// [RULE14] Trigger fills, drops old, waits line fall.
// [RULE15] Pull low on trigger, auto, software trigger.
// [RULE16] Acquire offers data out, holds line low.
// [RULE17] Block mode stops after one block collected.
// [RULE18] Continuous mode stops only on FIFO overflow.
// [RULE19] Stop releases line; line high returns idle.
// [RULE20] Measurement reset returns to parameter setup.
// [RULE21] Deferred parameters apply at measurement init.
// [RULE22] Only listed discrete sample rates accepted.
// [RULE23] Zero to sixteen halvings plus optional fifth.
`timescale 1ns/1ps
module ms_seq
    import ms_pkg::*;
#(
    parameter int SCLK_HALF = 4
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Register port.
    input wire ms_bus_t bus,
    output logic [REG_W-1:0] bus_rdata,
    // Backplane sync pin, open drain.
    input wire logic bp_sync_i,
    output logic bp_sync_o,
    output logic bp_sync_oe,
    // Events from neighbouring logic.
    input wire logic boot_done,
    input wire logic prearm_evt,
    input wire logic rpm_arm_evt,
    input wire logic trig_evt,
    input wire logic fifo_full,
    input wire ms_sample_t smp_in,
    // Sample stream toward the FIFO and output port.
    output ms_fifo_t fifo_out,
    output logic out_en,
    // Sample clock and active settings.
    output logic samp_clk,
    output ms_decim_t decim_act,
    output logic [4:0] rate_act
);

    if (SCLK_HALF < 1 || SCLK_HALF > 255) begin : g_chk
        $error("SCLK_HALF must lie in 1 to 255");
    end

    typedef struct packed {
        ms_state_t st;
        logic own_pull;
        logic [2:0] pin_sync;
        logic bp_low;
        logic line_prev;
        logic [CNT_W-1:0] cnt;
        logic stopped;
        logic [5:0] cfg;
        logic [CNT_W-1:0] settle_sh;
        logic [CNT_W-1:0] pretrig_sh;
        logic [CNT_W-1:0] block_sh;
        ms_decim_t decim_sh;
        logic [4:0] rate_sh;
        logic [CNT_W-1:0] settle_act;
        logic [CNT_W-1:0] pretrig_act;
        logic [CNT_W-1:0] block_act;
        ms_decim_t decim_act;
        logic [4:0] rate_act;
        ms_fifo_t fifo;
        logic out_en;
        logic [REG_W-1:0] rdata;
        logic [7:0] sdiv;
        logic sclk;
        logic bp_oe;
    } ms_regs_t;

    ms_regs_t r_reg;
    ms_regs_t r_next;

    logic multi;
    logic line_low;
    logic line_fall;
    logic wr_ctrl;
    logic [3:0] cmd;
    logic smp;

    // Without the backplane the line is only this module's own pull.
    assign multi = r_reg.cfg[CFG_MULTI];
    assign line_low = r_reg.own_pull | (multi & r_reg.bp_low); // RULE2 RULE3
    assign line_fall = line_low & ~r_reg.line_prev;
    // Commands act only in the cycle of the control write, so a later
    // state change never replays an old command.
    assign wr_ctrl = bus.wr && bus.addr == OFS_CTRL;
    assign cmd = wr_ctrl ? bus.wdata[3:0] : 4'h0;
    assign smp = smp_in.valid;

    always_comb begin
        r_next = r_reg;
        r_next.fifo.wr = 1'b0;
        r_next.fifo.drop = 1'b0;
        r_next.fifo.data = smp_in.data;
        r_next.line_prev = line_low;

        // Three flops on the pin; level accepted once the last two agree.
        // A one-cycle glitch on the backplane never reaches the sequencer,
        // at the price of about three cycles of latency.
        r_next.pin_sync = {r_reg.pin_sync[1:0], ~bp_sync_i};
        if (r_reg.pin_sync[1] == r_reg.pin_sync[2]) begin
            r_next.bp_low = r_reg.pin_sync[2];
        end

        // Free-running divider, never touched by the sequencer.
        // Gating it on state changes would let peer modules drift apart.
        if (r_reg.sdiv == 8'(SCLK_HALF - 1)) begin
            r_next.sdiv = 8'h00;
            r_next.sclk = ~r_reg.sclk; // RULE4
        end else begin
            r_next.sdiv = r_reg.sdiv + 8'h01;
        end

        // Register writes.
        if (bus.wr) begin
            case (bus.addr)
                OFS_CFG: r_next.cfg = bus.wdata[5:0];
                OFS_SETTLE: r_next.settle_sh = bus.wdata[CNT_W-1:0];
                OFS_PRETRIG: r_next.pretrig_sh = bus.wdata[CNT_W-1:0];
                OFS_BLOCK: r_next.block_sh = bus.wdata[CNT_W-1:0];
                OFS_DECIM: begin
                    if (bus.wdata[4:0] <= DEC_MAX_DIV2) begin // RULE23
                        r_next.decim_sh.div2 = bus.wdata[4:0];
                        r_next.decim_sh.div5 = bus.wdata[DEC_DIV5];
                    end
                end
                OFS_RATE: begin
                    if (bus.wdata[REG_W-1:5] == '0 &&
                        bus.wdata[4:0] < RATE_COUNT) begin // RULE22
                        r_next.rate_sh = bus.wdata[4:0];
                    end
                end
                default: ;
            endcase
        end

        // Register reads, answered in the following cycle.
        r_next.rdata = '0;
        if (bus.rd) begin
            case (bus.addr)
                OFS_CFG: r_next.rdata = REG_W'(r_reg.cfg);
                OFS_SETTLE: r_next.rdata = REG_W'(r_reg.settle_sh);
                OFS_PRETRIG: r_next.rdata = REG_W'(r_reg.pretrig_sh);
                OFS_BLOCK: r_next.rdata = REG_W'(r_reg.block_sh);
                OFS_DECIM: r_next.rdata = REG_W'(r_reg.decim_sh);
                OFS_RATE: r_next.rdata = REG_W'(r_reg.rate_sh);
                OFS_STATUS: r_next.rdata = REG_W'({r_reg.stopped,
                    r_reg.own_pull, line_low, r_reg.st});
                default: r_next.rdata = '0;
            endcase
        end

        case (r_reg.st)
            ST_PARAM_SETUP: begin
                if (cmd[CMD_INIT]) begin
                    r_next.own_pull = 1'b1;
                end
                if (line_fall) begin // RULE5
                    r_next.st = ST_BOOT_LOADING;
                    r_next.own_pull = 1'b1;
                    r_next.settle_act = r_reg.settle_sh; // RULE21
                    r_next.pretrig_act = r_reg.pretrig_sh; // RULE21
                    r_next.block_act = r_reg.block_sh; // RULE21
                    r_next.decim_act = r_reg.decim_sh; // RULE21
                    r_next.rate_act = r_reg.rate_sh; // RULE21
                end
            end
            ST_BOOT_LOADING: begin
                if (boot_done) begin // RULE6
                    r_next.own_pull = 1'b0;
                    r_next.st = ST_BOOTED;
                end
            end
            ST_BOOTED: begin
                // Once every module has let go, this one starts the fall.
                if (!line_low) begin
                    r_next.own_pull = 1'b1;
                end
                if (line_fall) begin // RULE7
                    r_next.own_pull = 1'b1;
                    r_next.cnt = '0;
                    r_next.st = ST_FILTER_SETTLE;
                end
            end
            ST_FILTER_SETTLE: begin
                if (r_reg.cnt >= r_reg.settle_act) begin // RULE8
                    r_next.st = ST_PREARM;
                end else if (smp) begin
                    r_next.cnt = r_reg.cnt + 1'b1;
                end
            end
            ST_PREARM: begin
                if (r_reg.own_pull && (r_reg.cfg[CFG_PREARM_AUTO] ||
                    prearm_evt)) begin // RULE9
                    r_next.own_pull = 1'b0;
                end
                if (!r_reg.own_pull && !line_low) begin // RULE1
                    r_next.st = ST_IDLE;
                    // Auto arm pulls in the very cycle idle begins.
                    r_next.own_pull = r_reg.cfg[CFG_AUTO_ARM]; // RULE11
                end
            end
            ST_IDLE: begin
                r_next.own_pull = r_reg.cfg[CFG_AUTO_ARM]; // RULE11
                // Shaft-speed and software arm do not wait for the line.
                if (line_fall || rpm_arm_evt || cmd[CMD_ARM]) begin // RULE10
                    r_next.st = ST_ARM;
                    r_next.own_pull = r_reg.pretrig_act != '0;
                    r_next.cnt = '0;
                end
            end
            ST_ARM: begin
                if (smp) begin
                    r_next.fifo.wr = 1'b1; // RULE12
                    if (r_reg.cnt < r_reg.pretrig_act) begin
                        r_next.cnt = r_reg.cnt + 1'b1;
                    end
                end
                // The pull follows the running count, so a pre-trigger of
                // zero lets go in the first arm cycle.
                r_next.own_pull = r_next.cnt < r_reg.pretrig_act; // RULE13
                if (!line_low) begin // RULE12
                    r_next.st = ST_TRIGGER;
                    r_next.own_pull = 1'b0;
                end
            end
            ST_TRIGGER: begin
                if (smp) begin
                    r_next.fifo.wr = 1'b1;
                    // Window full: the oldest sample goes out as one comes in.
                    if (r_reg.cnt >= r_reg.pretrig_act) begin
                        r_next.fifo.drop = 1'b1; // RULE14
                    end else begin
                        r_next.cnt = r_reg.cnt + 1'b1;
                    end
                end
                // Any one enabled source is enough; later ones change
                // nothing once the line is low.
                if ((trig_evt && r_reg.cfg[CFG_TRIG_DRIVE]) ||
                    r_reg.cfg[CFG_AUTO_TRIG] || cmd[CMD_TRIG]) begin
                    r_next.own_pull = 1'b1; // RULE15
                end
                if (line_fall) begin // RULE14
                    r_next.st = ST_ACQUIRE;
                    r_next.own_pull = 1'b1;
                    r_next.stopped = 1'b0;
                    r_next.out_en = 1'b1; // RULE16
                end
            end
            ST_ACQUIRE: begin
                // Block mode counts on from the pre-trigger count, so one
                // block includes the pre-trigger samples.
                if (!r_reg.stopped) begin
                    r_next.own_pull = 1'b1; // RULE16
                    if (r_reg.cfg[CFG_CONT]) begin
                        if (fifo_full) begin // RULE18
                            r_next.stopped = 1'b1;
                            r_next.own_pull = 1'b0; // RULE19
                        end else if (smp) begin
                            r_next.fifo.wr = 1'b1;
                        end
                    end else if (r_reg.cnt >= r_reg.block_act) begin
                        r_next.stopped = 1'b1; // RULE17
                        r_next.own_pull = 1'b0; // RULE19
                    end else if (smp) begin
                        r_next.fifo.wr = 1'b1;
                        r_next.cnt = r_reg.cnt + 1'b1;
                    end
                end else if (!line_low) begin // RULE19
                    r_next.st = ST_IDLE;
                    r_next.own_pull = r_reg.cfg[CFG_AUTO_ARM]; // RULE11
                    r_next.out_en = 1'b0;
                    r_next.stopped = 1'b0;
                end
            end
            default: begin
                // An illegal state code falls back to setup, line let go.
                r_next.st = ST_PARAM_SETUP;
                r_next.own_pull = 1'b0;
            end
        endcase

        // A measurement reset overrides any sequence step.
        if (cmd[CMD_RESET]) begin // RULE20
            r_next.st = ST_PARAM_SETUP;
            r_next.own_pull = 1'b0;
            r_next.out_en = 1'b0;
            r_next.stopped = 1'b0;
            r_next.fifo.wr = 1'b0;
            r_next.fifo.drop = 1'b0;
        end

        // The pin is driven only when the backplane is in use.
        r_next.bp_oe = r_next.own_pull & r_next.cfg[CFG_MULTI]; // RULE3
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            // Clear all, then set the fields whose reset value is not zero.
            r_reg <= '0;
            r_reg.st <= ST_PARAM_SETUP; // RULE5
            r_reg.cfg <= CFG_RESET;
            r_reg.settle_sh <= SETTLE_RESET;
            r_reg.block_sh <= BLOCK_RESET;
            r_reg.settle_act <= SETTLE_RESET;
            r_reg.block_act <= BLOCK_RESET;
            r_reg.rate_sh <= RATE_RESET;
            r_reg.rate_act <= RATE_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // The pin is open drain: it only ever pulls low, so the level is a
    // constant and the registered enable alone decides the drive.
    assign bp_sync_o = 1'b0;
    assign bp_sync_oe = r_reg.bp_oe;
    assign bus_rdata = r_reg.rdata;
    assign fifo_out = r_reg.fifo;
    assign out_en = r_reg.out_en;
    assign samp_clk = r_reg.sclk;
    assign decim_act = r_reg.decim_act;
    assign rate_act = r_reg.rate_act;

endmodule : ms_seq

// File: sim/ms_seq_asserts.sv
// Purpose: Port-level checks for the measurement sequencer.
// Assumes: Sees only ms_seq ports; the multi bit is tracked from writes.
// Notes: The run counter holds cycles since the last sample clock toggle.
`timescale 1ns/1ps
module ms_seq_asserts
    import ms_pkg::*;
#(
    parameter int SCLK_HALF = 4
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Register port.
    input wire ms_bus_t bus,
    input wire logic [REG_W-1:0] bus_rdata,
    // Sync pin.
    input wire logic bp_sync_o,
    input wire logic bp_sync_oe,
    // Stream and settings.
    input wire ms_sample_t smp_in,
    input wire ms_fifo_t fifo_out,
    input wire logic samp_clk,
    input wire ms_decim_t decim_act,
    input wire logic [4:0] rate_act
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic multi_reg;
    logic prev_reg;
    logic [7:0] run_reg;
    always_ff @(posedge core_clk) begin
        prev_reg <= samp_clk;
        if (rst) begin
            multi_reg <= 1'b0;
            run_reg <= 8'h00;
        end else begin
            if (bus.wr && bus.addr == OFS_CFG) begin
                multi_reg <= bus.wdata[CFG_MULTI];
            end
            run_reg <= (samp_clk != prev_reg) ? 8'h01 : run_reg + 8'h01;
        end
    end
    pin_low_a: assert property (bp_sync_o == 1'b0)
        else $error("sync pin driven high");
    single_quiet_a: assert property (
        bp_sync_oe |-> multi_reg || $past(multi_reg))
        else $error("backplane driven in single mode");
    sclk_steady_a: assert property (run_reg <= SCLK_HALF)
        else $error("sample clock paused");
    fifo_wr_a: assert property (fifo_out.wr |->
        $past(smp_in.valid) && fifo_out.data == $past(smp_in.data))
        else $error("fifo write without sample");
    drop_wr_a: assert property (fifo_out.drop |-> fifo_out.wr)
        else $error("drop without write");
    div_range_a: assert property (decim_act.div2 <= DEC_MAX_DIV2)
        else $error("halving count out of range");
    rate_range_a: assert property (rate_act < RATE_COUNT)
        else $error("rate index out of range");
    rdata_idle_a: assert property (!$past(bus.rd) |-> bus_rdata == '0)
        else $error("read data outside read slot");
endmodule : ms_seq_asserts

bind ms_seq ms_seq_asserts #(.SCLK_HALF(SCLK_HALF)) chk_u (
    .core_clk(core_clk),
    .rst(rst),
    .bus(bus),
    .bus_rdata(bus_rdata),
    .bp_sync_o(bp_sync_o),
    .bp_sync_oe(bp_sync_oe),
    .smp_in(smp_in),
    .fifo_out(fifo_out),
    .samp_clk(samp_clk),
    .decim_act(decim_act),
    .rate_act(rate_act)
);

// File: sim/ms_peer.sv
// Purpose: Peer module on the shared wire-OR sync line.
// Assumes: Line level is fed back after the pull-up.
// Notes: Holds the line low for LAG cycles after every fall, as a slower module would.
`timescale 1ns/1ps
module ms_peer #(
    parameter int LAG = 12
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Line and command.
    input wire logic line,
    input wire logic pull_req,
    output logic peer_oe
);
    logic prev_reg;
    int cnt_reg;
    always_ff @(posedge core_clk) begin
        prev_reg <= line;
        if (rst) begin
            cnt_reg <= 0;
        end else if (pull_req || (prev_reg && !line)) begin
            cnt_reg <= LAG;
        end else if (cnt_reg > 0) begin
            cnt_reg <= cnt_reg - 1;
        end
    end
    assign peer_oe = (cnt_reg > 0);
endmodule : ms_peer

// File: sim/measurement_sequencer_test.sv
// Purpose: Self-checking bench for the measurement sequencer.
// Assumes: One peer shares the line; samples arrive every fourth cycle.
// Notes: State is read back through the status register.
`timescale 1ns/1ps
module measurement_sequencer_test;
    import ms_pkg::*;
    logic core_clk, rst, fifo_full, bp_sync_o, bp_sync_oe, peer_oe;
    logic out_en, samp_clk;
    logic [4:0] evt, rate_act;
    logic [REG_W-1:0] bus_rdata, rdv;
    logic [23:0] scnt;
    ms_bus_t bus;
    ms_sample_t smp_in;
    ms_fifo_t fifo_out;
    ms_decim_t decim_act;
    int fail_count, n_compared, k;
    wire logic bp_line;
    // The line has a pull-up; any enabled driver holds it low.
    assign bp_line = !((bp_sync_oe && !bp_sync_o) || peer_oe);
    ms_seq #(.SCLK_HALF(4)) dut_u (.core_clk(core_clk), .rst(rst),
        .bus(bus), .bus_rdata(bus_rdata), .bp_sync_i(bp_line),
        .bp_sync_o(bp_sync_o), .bp_sync_oe(bp_sync_oe),
        .boot_done(evt[0]), .prearm_evt(evt[1]), .rpm_arm_evt(evt[2]),
        .trig_evt(evt[3]), .fifo_full(fifo_full), .smp_in(smp_in),
        .fifo_out(fifo_out), .out_en(out_en), .samp_clk(samp_clk),
        .decim_act(decim_act), .rate_act(rate_act));
    ms_peer #(.LAG(12)) peer_u (.core_clk(core_clk), .rst(rst),
        .line(bp_line), .pull_req(evt[4]), .peer_oe(peer_oe));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (rst) begin
            scnt <= '0;
            smp_in <= '0;
        end else begin
            scnt <= scnt + 24'h000001;
            smp_in <= '{valid: (scnt[1:0] == 2'h3), data: scnt};
        end
    end
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 rdv = bus_rdata;
    endtask : rd
    task automatic pulse(input int i);
        @(posedge core_clk);
        evt <= 5'h01 << i;
        @(posedge core_clk);
        evt <= 5'h00;
    endtask : pulse
    task automatic wait_st(input logic [3:0] st, input string what);
        for (int n = 0; n < 200; n++) begin
            rd(OFS_STATUS);
            if (rdv[3:0] === st) break;
        end
        check(what, {28'h0, rdv[3:0]}, {28'h0, st});
    endtask : wait_st
    task automatic single_loop();
        wait_st(4'h0, "reset state");
        check("rate idle", rate_act, RATE_RESET);
        rd(8'h40);
        check("unmapped", rdv, 32'h0);
        wr(OFS_SETTLE, 32'h2);
        wr(OFS_PRETRIG, 32'h2);
        wr(OFS_BLOCK, 32'h10);
        wr(OFS_DECIM, 32'h30);
        wr(OFS_RATE, 32'h1A);
        wr(OFS_DECIM, 32'h11);
        wr(OFS_RATE, 32'h1B);
        rd(OFS_DECIM);
        check("decim rd", rdv, 32'h30);
        wr(OFS_CFG, 32'h24);
        wr(OFS_CTRL, 32'h1);
        wait_st(4'h1, "boot");
        check("decim", decim_act, 6'h30);
        check("rate", rate_act, 5'h1A);
        repeat (20) @(posedge core_clk);
        wait_st(4'h1, "boot hold");
        pulse(0);
        wait_st(4'h5, "idle");
        k = 0;
        repeat (40) begin
            @(posedge core_clk);
            #1 k += (fifo_out.wr !== 1'b0);
        end
        check("idle writes", k, 0);
        wr(OFS_CTRL, 32'h2);
        wait_st(4'h6, "sw arm");
        wait_st(4'h8, "auto trig");
        check("out en", out_en, 1'b1);
        wait_st(4'h5, "block done");
        check("out off", out_en, 1'b0);
        pulse(2);
        wait_st(4'h6, "rpm arm");
        wr(OFS_CTRL, 32'h8);
        wait_st(4'h0, "meas reset");
        $display("single_loop done");
    endtask : single_loop
    task automatic multi_peer();
        wr(OFS_CFG, 32'h19);
        wr(OFS_CTRL, 32'h1);
        wait_st(4'h1, "multi boot");
        pulse(0);
        wait_st(4'h4, "prearm");
        repeat (20) @(posedge core_clk);
        wait_st(4'h4, "prearm hold");
        pulse(1);
        wait_st(4'h5, "multi idle");
        pulse(4);
        wait_st(4'h6, "peer arm");
        wait_st(4'h7, "trigger");
        pulse(3);
        wait_st(4'h8, "trig drive");
        check("hold low", bp_sync_oe, 1'b1);
        repeat (100) @(posedge core_clk);
        wait_st(4'h8, "cont run");
        @(posedge core_clk);
        fifo_full <= 1'b1;
        wait_st(4'h5, "overflow stop");
        check("released", bp_sync_oe, 1'b0);
        @(posedge core_clk);
        fifo_full <= 1'b0;
        $display("multi_peer done");
    endtask : multi_peer
    task automatic sw_trigger();
        wr(OFS_CFG, 32'h02);
        wait_st(4'h6, "auto arm");
        wait_st(4'h7, "arm release");
        pulse(3);
        rd(OFS_STATUS);
        check("trig undriven", rdv[3:0], 4'h7);
        k = 0;
        repeat (16) begin
            @(posedge core_clk);
            #1 k += (fifo_out.drop !== 1'b0);
        end
        check("window drop", k, 4);
        wr(OFS_CTRL, 32'h4);
        wait_st(4'h8, "sw trig");
        wr(OFS_CTRL, 32'h8);
        wait_st(4'h0, "loop reset");
        $display("sw_trigger done");
    endtask : sw_trigger
    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        rst = 1'b1;
        bus = '0;
        evt = '0;
        fifo_full = 1'b0;
        fail_count = 0;
        n_compared = 0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        single_loop();
        multi_peer();
        sw_trigger();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        $display("Watchdog expired");
        stop_test();
    end
endmodule : measurement_sequencer_test
